// [rtl/bmlc_pkg.sv]
// What this block does
// - Buttons are ignored while the local control lock is set.
// - Both buttons held 2 s to under 10 s toggle auto/manual state.
// - Link indicator flashes at 5 Hz during the first 2 s of a combined hold.
// - In manual state the RGB indicator flashes orange (function check).
// - In manual state a short press of button 2 switches the pilot valve.
// - Combined hold over 10 s, under 30 s restarts; three LEDs flash 5 Hz.
// - Combined hold over 30 s restores factory settings; three LEDs flash 10 Hz.
// - Auto state, button 1 alone over 5 s, under 10 s: auto teach, 5 Hz.
// - Auto state, button 1 alone over 10 s, under 30 s: manual teach, 10 Hz.
// - Automatic state drives the valve from the controller command.
// - Pilot drive indicator is lit while the pilot valve is energised.
// - Calibration indicator flashes while teaching, lit steadily after teach failure.
// - RGB display mode: valve, valve with warnings (default), standard, fixed, off.
// - Display mode and position colours are writable by software.
// - With several conditions, only the highest priority shows; failure highest.
package bmlc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ   = 250_000_000;
  localparam int MS_PER_S      = 1000;
  localparam int T_SWITCH_MS   = 2000;
  localparam int T_TEACH_MS    = 5000;
  localparam int T_RESTART_MS  = 10000;
  localparam int T_FACTORY_MS  = 30000;
  localparam int FLASH_SLOW_HZ = 5;
  localparam int FLASH_FAST_HZ = 10;
  localparam int SLOW_HALF_MS  = MS_PER_S / (2 * FLASH_SLOW_HZ);
  localparam int FAST_HALF_MS  = MS_PER_S / (2 * FLASH_FAST_HZ);
  localparam int HOLD_W        = 16;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_COLOR    = 8'h10;
  localparam int CTRL_LOCK    = 0;
  localparam int CTRL_MODE    = 1;
  localparam int COL_OPEN     = 0;
  localparam int COL_CLOSED   = 3;
  localparam int COL_FIXED    = 6;
  localparam int IRQ_MODE     = 0;
  localparam int IRQ_RESTART  = 1;
  localparam int IRQ_FACTORY  = 2;
  localparam int IRQ_TEACH    = 3;
  localparam int IRQ_TFAIL    = 4;
  localparam int IRQ_W        = 5;

  // ----------------------------------------------------------------
  // Colours and display modes
  // ----------------------------------------------------------------
  localparam logic [2:0] C_OFF    = 3'h0;
  localparam logic [2:0] C_WHITE  = 3'h1;
  localparam logic [2:0] C_GREEN  = 3'h2;
  localparam logic [2:0] C_BLUE   = 3'h3;
  localparam logic [2:0] C_YELLOW = 3'h4;
  localparam logic [2:0] C_ORANGE = 3'h5;
  localparam logic [2:0] C_RED    = 3'h6;
  localparam logic [2:0] MODE_VALVE = 3'h0;
  localparam logic [2:0] MODE_WARN  = 3'h1;
  localparam logic [2:0] MODE_STD   = 3'h2;
  localparam logic [2:0] MODE_FIXED = 3'h3;
  localparam logic [2:0] MODE_OFF   = 3'h4;
  localparam logic [3:0] CTRL_RST   = {MODE_WARN, 1'b0};
  localparam logic [8:0] COLOR_RST  = {C_GREEN, C_GREEN, C_YELLOW};

  typedef enum logic [2:0] {S_IDLE, S_ONE, S_TWO, S_BOTH, S_WAIT} bmlc_state_t;
endpackage

// [rtl/bmlc_top.sv]
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module bmlc_top
  import bmlc_pkg::*;
#(
  parameter int MS_CYCLES = CLK_FREQ_HZ / MS_PER_S
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  output logic             irq_o,
  // Operator buttons
  input  wire logic        btn1_i,
  input  wire logic        btn2_i,
  // Device conditions and controller
  input  wire logic        ctrl_valve_i,
  input  wire logic        link_active_i,
  input  wire logic        dev_fail_i,
  input  wire logic        dev_oos_i,
  input  wire logic        dev_maint_i,
  input  wire logic        pos_open_i,
  input  wire logic        pos_closed_i,
  input  wire logic        teach_done_i,
  input  wire logic        teach_fail_i,
  // Actions
  output logic             pilot_valve_o,
  output logic             manual_state_o,
  output logic             restart_o,
  output logic             factory_reset_o,
  output logic             teach_auto_o,
  output logic             teach_manual_o,
  // Indicators
  output logic             link_activity_indicator_o,
  output logic             calibration_indicator_o,
  output logic             pilot_drive_indicator_o,
  output logic [2:0]       rgb_condition_indicator_o
);

  function automatic logic [2:0] col_field(input logic [8:0] r, input int lsb);
    col_field = r[lsb+:3];
  endfunction

  // ----------------------------------------------------------------
  // Button synchronisers and time base
  // ----------------------------------------------------------------
  logic [1:0]        b1_s;
  logic [1:0]        b2_s;
  logic [17:0]       ms_cnt;
  logic              ms_tick;
  logic [6:0]        slow_cnt;
  logic [6:0]        fast_cnt;
  logic              slow_ph;
  logic              fast_ph;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      b1_s <= 2'h0;
      b2_s <= 2'h0;
    end else begin
      b1_s <= {b1_s[0], btn1_i};
      b2_s <= {b2_s[0], btn2_i};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_cnt   <= 18'h0;
      ms_tick  <= 1'b0;
      slow_cnt <= 7'h0;
      fast_cnt <= 7'h0;
      slow_ph  <= 1'b0;
      fast_ph  <= 1'b0;
    end else begin
      ms_tick <= (ms_cnt == 18'(MS_CYCLES - 1));
      ms_cnt  <= (ms_cnt == 18'(MS_CYCLES - 1)) ? 18'h0 : ms_cnt + 18'h1;
      if (ms_tick) begin
        slow_cnt <= (slow_cnt == 7'(SLOW_HALF_MS - 1)) ? 7'h0 : slow_cnt + 7'h1;
        fast_cnt <= (fast_cnt == 7'(FAST_HALF_MS - 1)) ? 7'h0 : fast_cnt + 7'h1;
        if (slow_cnt == 7'(SLOW_HALF_MS - 1)) slow_ph <= ~slow_ph;
        if (fast_cnt == 7'(FAST_HALF_MS - 1)) fast_ph <= ~fast_ph;
      end
    end
  end

  // ----------------------------------------------------------------
  // Press decoder
  // ----------------------------------------------------------------
  bmlc_state_t       st;
  bmlc_state_t       next_st;
  logic [HOLD_W-1:0] hold;
  logic              lock;
  logic [2:0]        mode;
  logic [8:0]        colors;
  logic              man_valve;
  logic              teach_busy;
  logic              teach_fast;
  logic              teach_err;

  wire b1   = b1_s[1];
  wire b2   = b2_s[1];
  wire both = b1 & b2;
  wire none = ~b1 & ~b2;

  always_comb begin
    next_st = st;
    case (st)
      S_IDLE: begin
        if (!lock && both) next_st = S_BOTH;
        else if (!lock && b1) next_st = S_ONE;
        else if (!lock && b2) next_st = S_TWO;
      end
      S_ONE: begin
        if (lock) next_st = S_WAIT;
        else if (both) next_st = S_BOTH;
        else if (!b1) next_st = S_IDLE;
      end
      S_TWO: begin
        if (lock) next_st = S_WAIT;
        else if (both) next_st = S_BOTH;
        else if (!b2) next_st = S_IDLE;
      end
      S_BOTH: begin
        if (lock || !both) next_st = S_WAIT;
      end
      S_WAIT: begin
        if (none) next_st = S_IDLE;
      end
      default: next_st = S_IDLE;
    endcase
  end

  // Actions fire on release, never when a threshold passes
  wire rel_both   = (st == S_BOTH) && !both && !lock;
  wire do_toggle  = rel_both && hold >= HOLD_W'(T_SWITCH_MS) && hold < HOLD_W'(T_RESTART_MS);
  wire do_restart = rel_both && hold > HOLD_W'(T_RESTART_MS) && hold < HOLD_W'(T_FACTORY_MS);
  wire do_factory = rel_both && hold > HOLD_W'(T_FACTORY_MS);
  wire rel_one    = (st == S_ONE) && none && !lock && !manual_state_o;
  wire do_tauto   = rel_one && hold > HOLD_W'(T_TEACH_MS) && hold < HOLD_W'(T_RESTART_MS);
  wire do_tman    = rel_one && hold > HOLD_W'(T_RESTART_MS) && hold < HOLD_W'(T_FACTORY_MS);
  wire do_valve   = (st == S_TWO) && none && !lock && manual_state_o && hold < HOLD_W'(T_SWITCH_MS);
  wire valve_on   = manual_state_o ? man_valve : ctrl_valve_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st   <= S_IDLE;
      hold <= '0;
    end else begin
      st <= next_st;
      if (next_st != st) hold <= '0;
      else if (ms_tick && hold != '1) hold <= hold + HOLD_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      manual_state_o <= 1'b0;
      man_valve      <= 1'b0;
      teach_busy     <= 1'b0;
      teach_fast     <= 1'b0;
      teach_err      <= 1'b0;
    end else begin
      if (do_factory) manual_state_o <= 1'b0;
      else if (do_toggle) manual_state_o <= ~manual_state_o;
      if (!manual_state_o) man_valve <= 1'b0;
      else if (do_valve) man_valve <= ~man_valve;
      if (do_tauto || do_tman) begin
        teach_busy <= 1'b1;
        teach_fast <= do_tman;
        teach_err  <= 1'b0;
      end else if (teach_fail_i && teach_busy) begin
        teach_busy <= 1'b0;
        teach_err  <= 1'b1;
      end else if (teach_done_i) begin
        teach_busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------
  wire in_both  = (st == S_BOTH);
  wire seq_slow = in_both && hold > HOLD_W'(T_RESTART_MS) && hold < HOLD_W'(T_FACTORY_MS);
  wire seq_fast = in_both && hold > HOLD_W'(T_FACTORY_MS);
  wire seq_any  = seq_slow | seq_fast;
  wire seq_ph   = seq_fast ? fast_ph : slow_ph;
  wire one_auto = (st == S_ONE) && !manual_state_o;
  wire teach_ph = teach_fast ? fast_ph : slow_ph;

  wire next_link = (in_both && hold < HOLD_W'(T_SWITCH_MS)) ? slow_ph :
                   seq_any ? seq_ph : (link_active_i & slow_ph);
  wire next_pilot = seq_any ? seq_ph : valve_on;
  wire next_cal = seq_any ? seq_ph :
                  (one_auto && hold > HOLD_W'(T_RESTART_MS)) ? fast_ph :
                  (one_auto && hold > HOLD_W'(T_TEACH_MS)) ? slow_ph :
                  teach_busy ? teach_ph : teach_err;

  wire       func_chk = manual_state_o | teach_busy;
  wire       warn     = dev_fail_i | func_chk | dev_oos_i | dev_maint_i;
  wire [2:0] stat_col = dev_fail_i ? C_RED : func_chk ? C_ORANGE :
                        dev_oos_i ? C_YELLOW : dev_maint_i ? C_BLUE : C_GREEN;
  wire [2:0] pos_col  = pos_open_i ? col_field(colors, COL_OPEN) :
                        pos_closed_i ? col_field(colors, COL_CLOSED) : C_OFF;
  wire [2:0] next_rgb = (mode == MODE_VALVE) ? ((manual_state_o && slow_ph) ? C_ORANGE : pos_col) :
                        (mode == MODE_WARN) ? ((warn && slow_ph) ? stat_col : pos_col) :
                        (mode == MODE_STD) ? ((warn && !slow_ph) ? C_OFF : stat_col) :
                        (mode == MODE_FIXED) ? col_field(colors, COL_FIXED) : C_OFF;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_activity_indicator_o <= 1'b0;
      calibration_indicator_o   <= 1'b0;
      pilot_drive_indicator_o   <= 1'b0;
      rgb_condition_indicator_o <= C_OFF;
      pilot_valve_o             <= 1'b0;
      restart_o                 <= 1'b0;
      factory_reset_o           <= 1'b0;
      teach_auto_o              <= 1'b0;
      teach_manual_o            <= 1'b0;
    end else begin
      link_activity_indicator_o <= next_link;
      calibration_indicator_o   <= next_cal;
      pilot_drive_indicator_o   <= next_pilot;
      rgb_condition_indicator_o <= next_rgb;
      pilot_valve_o             <= valve_on;
      restart_o                 <= do_restart;
      factory_reset_o           <= do_factory;
      teach_auto_o              <= do_tauto;
      teach_manual_o            <= do_tman;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite registers and interrupt
  // ----------------------------------------------------------------
  logic             wr_pend;
  logic [7:0]       wr_addr;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;

  wire              acc    = hsel_i & hready_i & htrans_i[1];
  wire              wr_ctl = wr_pend && wr_addr == REG_CTRL;
  wire              wr_col = wr_pend && wr_addr == REG_COLOR;
  wire              wr_msk = wr_pend && wr_addr == REG_IRQ_MASK;
  wire [IRQ_W-1:0]  irq_clr = (wr_pend && wr_addr == REG_IRQ_STAT) ? hwdata_i[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0]  irq_ev = {teach_fail_i & teach_busy, do_tauto | do_tman, do_factory, do_restart, do_toggle};
  wire [7:0]        ra     = haddr_i[7:0];
  wire [31:0]       rd_val = (ra == REG_CTRL) ? {28'h0, mode, lock} :
                             (ra == REG_STATUS) ? {25'h0, teach_err, teach_busy, valve_on, manual_state_o, st} :
                             (ra == REG_IRQ_STAT) ? {27'h0, irq_stat} :
                             (ra == REG_IRQ_MASK) ? {27'h0, irq_mask} :
                             (ra == REG_COLOR) ? {23'h0, colors} : 32'h0;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend     <= 1'b0;
      wr_addr     <= 8'h0;
      hrdata_o    <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      wr_pend <= acc & hwrite_i;
      if (acc) wr_addr <= ra;
      if (acc && !hwrite_i) hrdata_o <= rd_val;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock     <= CTRL_RST[CTRL_LOCK];
      mode     <= CTRL_RST[CTRL_MODE+:3];
      colors   <= COLOR_RST;
      irq_stat <= '0;
      irq_mask <= '0;
      irq_o    <= 1'b0;
    end else begin
      if (do_factory) begin
        lock   <= CTRL_RST[CTRL_LOCK];
        mode   <= CTRL_RST[CTRL_MODE+:3];
        colors <= COLOR_RST;
      end else begin
        if (wr_ctl) lock <= hwdata_i[CTRL_LOCK];
        if (wr_ctl) mode <= hwdata_i[CTRL_MODE+:3];
        if (wr_col) colors <= hwdata_i[8:0];
      end
      if (wr_msk) irq_mask <= hwdata_i[IRQ_W-1:0];
      // A new event wins over a same-cycle clear
      irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
      irq_o    <= |(irq_stat & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  wire [2:0] seq_leds = {pilot_drive_indicator_o, calibration_indicator_o, link_activity_indicator_o};

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Press decoding and actions
  a_lock_blocks: assert property (lock |=> st == S_IDLE || st == S_WAIT)
    else $error("button decoder active while locked");

  a_mode_toggle: assert property (do_toggle && !do_factory |=> manual_state_o != $past(manual_state_o))
    else $error("operating state did not toggle");

  a_short_combo: assert property (rel_both && hold < HOLD_W'(T_SWITCH_MS) |=> $stable(manual_state_o))
    else $error("short combined press changed state");

  a_restart_range: assert property ($rose(restart_o) |-> $past(hold) > HOLD_W'(T_RESTART_MS) && $past(hold) < HOLD_W'(T_FACTORY_MS))
    else $error("restart outside hold window");

  a_factory_auto: assert property (do_factory |=> !manual_state_o && !lock
                                   && mode == CTRL_RST[CTRL_MODE+:3] && colors == COLOR_RST)
    else $error("factory reset left old settings");

  a_valve_switch: assert property (do_valve |=> man_valve != $past(man_valve))
    else $error("manual valve did not switch");

  a_auto_valve: assert property (!manual_state_o |=> pilot_valve_o == $past(ctrl_valve_i))
    else $error("automatic state not following controller");

  a_teach_auto: assert property (do_tauto |=> teach_auto_o && teach_busy && !teach_fast)
    else $error("automatic teach not started");

  a_teach_manual: assert property (do_tman |=> teach_manual_o && teach_busy && teach_fast)
    else $error("manual teach not started");

  // Indicators
  a_link_flash: assert property (in_both && hold < HOLD_W'(T_SWITCH_MS) |=> link_activity_indicator_o == $past(slow_ph))
    else $error("link indicator not following slow flash");

  a_seq_slow: assert property (seq_slow |=> seq_leds == {3{$past(slow_ph)}})
    else $error("restart flash not at slow rate");

  a_seq_fast: assert property (seq_fast |=> seq_leds == {3{$past(fast_ph)}})
    else $error("factory flash not at fast rate");

  a_pilot_drive_indicator: assert property (!seq_any |=> pilot_drive_indicator_o == $past(valve_on))
    else $error("pilot indicator disagrees with valve");

  a_teach_fail: assert property (teach_err && !teach_busy && !seq_any && st != S_ONE |=> calibration_indicator_o)
    else $error("teach failure not lit steadily");

  a_err_idle: assert property (teach_err |-> !teach_busy)
    else $error("teach failure while teach running");

  // Status display and interrupt
  a_manual_orange: assert property (mode == MODE_WARN && manual_state_o && !dev_fail_i && slow_ph
                                    |=> rgb_condition_indicator_o == C_ORANGE)
    else $error("manual state not shown orange");

  a_fail_first: assert property (mode == MODE_STD && dev_fail_i && slow_ph |=> rgb_condition_indicator_o == C_RED)
    else $error("failure not given priority");

  a_fixed_colour: assert property (mode == MODE_FIXED
                                   |=> rgb_condition_indicator_o == $past(col_field(colors, COL_FIXED)))
    else $error("fixed colour not shown");

  a_display_off: assert property (mode == MODE_OFF |=> rgb_condition_indicator_o == C_OFF)
    else $error("display not dark in off mode");

  a_irq_level: assert property (|(irq_stat & irq_mask) |=> irq_o)
    else $error("interrupt not raised");
endmodule
`default_nettype wire

// [test/bmlc_operator.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Operator at the two push buttons
// ----------------------------------------------------------------
module bmlc_operator (
  // Clock
  input  wire logic clk_i,
  // Buttons, high while held
  output var logic  btn1_o,
  output var logic  btn2_o
);
  initial begin
    btn1_o = 1'b0;
    btn2_o = 1'b0;
  end

  // The requested buttons go down and up together, then time for the release to act
  task automatic press(input logic b1, input logic b2, input int cyc);
    @(posedge clk_i);
    btn1_o <= b1;
    btn2_o <= b2;
    repeat (cyc) @(posedge clk_i);
    btn1_o <= 1'b0;
    btn2_o <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// [test/bmlc_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module bmlc_tb_top;
  import bmlc_pkg::*;
  localparam int MSC = 1;
  logic        clk = 1'b0, rst_n, hsel, hwrite, b1, b2, ctrl_valve, dev_fail, dev_maint, pos_open, t_done, t_fail;
  logic [1:0]  htrans;
  logic [2:0]  hsize, rgb, leds_q;
  logic [31:0] haddr, hwdata, hrdata;
  logic        hready, hresp, irq, pilot, manual, restart, factory, t_auto, t_man, led_link, led_cal, led_pilot;
  wire  logic [2:0] leds;
  int          error_cnt = 0, tests_run = 0, c, chg[3], pulses[4], cs[3];
  logic        f, g;

  assign leds = {led_pilot, led_cal, led_link};
  always #2 clk = ~clk;

  bmlc_top #(.MS_CYCLES(MSC)) u_dut (
    .clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
    .hrdata_o(hrdata), .irq_o(irq), .btn1_i(b1), .btn2_i(b2), .ctrl_valve_i(ctrl_valve),
    .link_active_i(1'b0), .dev_fail_i(dev_fail), .dev_oos_i(1'b0), .dev_maint_i(dev_maint),
    .pos_open_i(pos_open), .pos_closed_i(1'b0), .teach_done_i(t_done), .teach_fail_i(t_fail),
    .pilot_valve_o(pilot), .manual_state_o(manual), .restart_o(restart), .factory_reset_o(factory),
    .teach_auto_o(t_auto), .teach_manual_o(t_man), .link_activity_indicator_o(led_link),
    .calibration_indicator_o(led_cal), .pilot_drive_indicator_o(led_pilot), .rgb_condition_indicator_o(rgb)
  );
  bmlc_operator u_op (.clk_i(clk), .btn1_o(b1), .btn2_o(b2));

  // ----------------------------------------------------------------
  // Monitors and helpers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    leds_q <= leds;
    for (int i = 0; i < 3; i++) begin
      if (leds[i] !== leds_q[i]) chg[i]++;
    end
    if (restart === 1'b1) pulses[0]++;
    if (factory === 1'b1) pulses[1]++;
    if (t_auto === 1'b1) pulses[2]++;
    if (t_man === 1'b1) pulses[3]++;
  end

  task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", s, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    check("hready", hready, 1);
  endtask

  // One single word transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rdat = hrdata;
    check("hresp", hresp, 0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
    logic [31:0] x;
    ahb(1'b0, a, 32'h00000000, x);
    check(s, x, e);
  endtask

  task automatic both_flash(input int skip, input int win, input int lo, input int hi);
    fork
      u_op.press(1'b1, 1'b1, (skip + win + 200) * MSC);
      begin
        tick(skip * MSC);
        cs = chg;
        tick(win * MSC);
        for (int i = 0; i < 3; i++) check("led flashing", (chg[i] - cs[i]) inside {[lo:hi]}, 1);
      end
    join
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check("manual after reset", manual, 0);
    rd(REG_CTRL, {28'h0000000, CTRL_RST}, "ctrl reset");
    rd(REG_COLOR, {23'h000000, COLOR_RST}, "color reset");
    rd(REG_IRQ_MASK, 32'h00000000, "mask reset");
    rd(8'h20, 32'h00000000, "unmapped");
    $display("reset test done");
  endtask

  task automatic t_toggle();
    fork
      u_op.press(1'b1, 1'b1, 2500 * MSC);
      begin
        tick(60 * MSC);
        c = chg[0];
        tick(1900 * MSC);
        check("link flash", (chg[0] - c) inside {[15:21]}, 1);
      end
    join
    check("manual entered", manual, 1);
    rd(REG_IRQ_STAT, 32'h00000001, "irq stat");
    check("irq masked", irq, 0);
    wr(REG_IRQ_MASK, 32'h00000001);
    tick(2);
    check("irq raised", irq, 1);
    wr(REG_IRQ_STAT, 32'h00000001);
    tick(2);
    check("irq cleared", irq, 0);
    f = 1'b0;
    repeat (400) begin
      @(posedge clk);
      if (rgb === C_ORANGE) f = 1'b1;
    end
    check("orange in manual", f, 1);
    $display("toggle test done");
  endtask

  task automatic t_manual();
    f = pilot;
    u_op.press(1'b0, 1'b1, 50 * MSC);
    check("valve toggled", pilot, !f);
    check("valve lamp", led_pilot, !f);
    u_op.press(1'b0, 1'b1, 50 * MSC);
    check("valve back", pilot, f);
    u_op.press(1'b1, 1'b1, 1500 * MSC);
    check("short combo ignored", manual, 1);
    u_op.press(1'b1, 1'b1, 2500 * MSC);
    check("auto again", manual, 0);
    @(posedge clk);
    ctrl_valve <= 1'b1;
    tick(4);
    check("auto valve on", pilot, 1);
    check("auto valve lamp", led_pilot, 1);
    ctrl_valve <= 1'b0;
    tick(4);
    check("auto valve off", pilot, 0);
    wr(REG_CTRL, {28'h0000000, CTRL_RST} | 32'h00000001);
    u_op.press(1'b1, 1'b1, 2500 * MSC);
    check("locked", manual, 0);
    wr(REG_CTRL, {28'h0000000, CTRL_RST});
    $display("manual test done");
  endtask

  task automatic t_teach();
    fork
      u_op.press(1'b1, 1'b0, 6000 * MSC);
      begin
        tick(5100 * MSC);
        c = chg[1];
        tick(800 * MSC);
        check("teach slow flash", (chg[1] - c) inside {[6:10]}, 1);
      end
    join
    check("auto teach", pulses[2], 1);
    @(posedge clk);
    t_fail <= 1'b1;
    @(posedge clk);
    t_fail <= 1'b0;
    tick(4);
    c = chg[1];
    tick(300);
    check("teach fail lit", {led_cal, chg[1] == c}, 2'b11);
    fork
      u_op.press(1'b1, 1'b0, 12000 * MSC);
      begin
        tick(10100 * MSC);
        c = chg[1];
        tick(1800 * MSC);
        check("teach fast flash", (chg[1] - c) inside {[32:40]}, 1);
      end
    join
    check("manual teach", pulses[3], 1);
    c = chg[1];
    tick(400);
    check("teach running", (chg[1] - c) >= 6, 1);
    t_done <= 1'b1;
    @(posedge clk);
    t_done <= 1'b0;
    tick(4);
    check("teach ended", led_cal, 0);
    $display("teach test done");
  endtask

  task automatic t_display();
    pos_open <= 1'b1;
    wr(REG_CTRL, {28'h0000000, MODE_VALVE, 1'b0});
    tick(3);
    check("valve mode open", rgb, C_YELLOW);
    wr(REG_COLOR, 32'h00000054);
    wr(REG_CTRL, {28'h0000000, MODE_FIXED, 1'b0});
    tick(3);
    check("fixed colour", rgb, C_WHITE);
    wr(REG_CTRL, {28'h0000000, MODE_OFF, 1'b0});
    tick(3);
    check("display off", rgb, C_OFF);
    wr(REG_CTRL, {28'h0000000, MODE_STD, 1'b0});
    dev_fail <= 1'b1;
    dev_maint <= 1'b1;
    f = 1'b0;
    g = 1'b0;
    repeat (400) begin
      @(posedge clk);
      if (rgb === C_RED) f = 1'b1;
      if (rgb === C_BLUE) g = 1'b1;
    end
    check("priority", {f, g}, 2'b10);
    dev_fail <= 1'b0;
    dev_maint <= 1'b0;
    $display("display test done");
  endtask

  task automatic t_restart();
    both_flash(10100, 1800, 15, 21);
    check("restart", pulses[0], 1);
    check("no factory", pulses[1], 0);
    wr(REG_CTRL, {28'h0000000, MODE_OFF, 1'b0});
    both_flash(30100, 500, 8, 12);
    check("factory", pulses[1], 1);
    check("no restart", pulses[0], 1);
    rd(REG_CTRL, {28'h0000000, CTRL_RST}, "ctrl restored");
    rd(REG_COLOR, {23'h000000, COLOR_RST}, "color restored");
    $display("restart test done");
  endtask

  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    {rst_n, hsel, hwrite, ctrl_valve, dev_fail, dev_maint, pos_open, t_done, t_fail} = '0;
    htrans = 2'b00;
    hsize = 3'h2;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    tick(10);
    rst_n <= 1'b1;
    tick(2);
    t_reset();
    t_toggle();
    t_manual();
    t_teach();
    t_display();
    t_restart();
    print_verdict();
  end
endmodule
`default_nettype wire
